// ===== design/phy_pkg.sv
/*
  Shared constants, register map and carrier types for the transceiver
  sleep, low-power-idle and management block.
  Assumes a single 25 MHz system clock that is also the RMII clock.
*/
package phy_pkg;
    // Management register indices
    localparam logic [4:0]  REG_BASIC      = 5'h00;
    localparam logic [4:0]  REG_STATUS     = 5'h01;
    localparam logic [4:0]  REG_IND_CTL    = 5'h0D;
    localparam logic [4:0]  REG_IND_DATA   = 5'h0E;
    localparam logic [4:0]  REG_ANALOG_TWO = 5'h13;
    localparam logic [4:0]  REG_SLEEP      = 5'h14;
    localparam logic [4:0]  REG_FUNC_CTL   = 5'h1C;
    // Reset values and masks
    localparam logic [15:0] BASIC_RST      = 16'h2100;
    localparam logic [15:0] STATUS_FIXED   = 16'h7849;
    localparam logic [15:0] ANALOG_KEEP    = 16'h0303;
    localparam logic [15:0] ZERO_RST       = 16'h0000;
    // Sleep control bits
    localparam int SLP_METHOD = 6;
    localparam int SLP_MANUAL = 5;
    localparam int SLP_RETAIN = 4;
    localparam int SLP_EN     = 3;
    localparam int SLP_EXT    = 1;
    localparam int SLP_POL    = 0;
    // Other field positions
    localparam int FUNC_LOOP    = 1;
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_LINK    = 2;
    localparam int EEE_ADV_BIT  = 1;
    localparam logic [4:0]  EEE_DEV     = 5'h07;
    localparam logic [15:0] EEE_ADV_REG = 16'h003C;
    localparam logic [1:0]  FN_ADDR     = 2'h0;
    localparam logic [1:0]  FN_INC_RW   = 2'h2;
    localparam logic [1:0]  FN_INC_W    = 2'h3;
    localparam logic [1:0]  LPI_CODE    = 2'h1;
    // Timing
    localparam int CLK_HZ            = 25_000_000;
    localparam int REFRESH_PERIOD_MS = 20;
    localparam int REFRESH_BURST_US  = 200;
    localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * (CLK_HZ / 1000);
    localparam int REFRESH_BURST_CYC  = REFRESH_BURST_US * (CLK_HZ / 1_000_000);
    localparam logic [10:0] DET_SHORT_CYC = 11'h040;
    localparam logic [10:0] DET_LONG_CYC  = 11'h400;
    localparam logic [5:0]  PREAMBLE_LEN  = 6'h20;

    typedef struct packed {
        logic       soft_reset;
        logic       loopback;
        logic       speed_100;
        logic       an_enable;
        logic       power_down;
        logic       isolate;
        logic       restart_an;
        logic       full_duplex;
        logic       col_test;
        logic [6:0] rsvd;
    } basic_ctl_t;

    typedef struct packed {
        logic       crs_dv;
        logic [1:0] rxd;
    } rx_bus_t;

    typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_WR, MD_RD} mdio_st_t;
    typedef enum logic {PW_RUN, PW_SLEEP} power_st_t;
endpackage

// ===== design/phy_sleep_lpi_control.sv
/*
  Sleep, energy-detect, low-power-idle and management register logic of a
  10/100 transceiver, reached by serial management frames on mdc/mdio.
  Assumes sys_clk is the RMII clock; mdc, mdio and energy_in are pins.
*/
// What this block does
// - Energy output held high after power-on until sleep feature enabled.
// - Sleep control bit 4 gates access to the retained register copy.
// - Bit 3 enables deep sleep and lets energy output follow cable.
// - Bit 6 clear selects automatic sleep on loss of cable energy.
// - Automatic mode: signal loss enters sleep and, with bit 0 clear, drops energy output.
// - Automatic mode: signal return wakes up and, with bit 0 clear, raises energy output.
// - Hardware reset also brings the device out of deep sleep.
// - Sleep register and analog bits 9:8,1:0 survive sleep, not reset.
// - Leave low-power idle quickly; transmit and receive idle independent.
// - Idle function off at reset; enabled via indirect 7/3Ch then restart.
// - In transmit idle send refresh bursts on a fixed period.
// - Transmit idle while enable low and data 01; exit on any change.
// - Partner sleep codes give CRS_DV low and RXD 01.
// - 32 direct registers; indirect space through Dh and Eh.
// - Basic control bit 15 starts software reset and self-clears.
// - Bit 14 loops RMII transmit to receive when function reg agrees.
// - With autonegotiation on, result overrides speed and duplex bits.
// - Leaving power-down by reset needs two writes; first clears it.
// - Bit 10 isolates RMII; bit 9 restarts negotiation, self-clears.
// - While bit 3 is zero, sleep disabled and energy output forced true.
// - Indirect function field: address, data, increment rw or w only.
`timescale 1ns/1ps
module phy_sleep_lpi_control #(
    parameter logic [4:0] PHY_ADDR       = 5'h01,
    parameter int         REFRESH_PERIOD = phy_pkg::REFRESH_PERIOD_CYC,
    parameter int         REFRESH_BURST  = phy_pkg::REFRESH_BURST_CYC
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // Management pins
    input  wire logic             mdc,
    input  wire logic             mdio_in,
    output logic                  mdio_out,
    output logic                  mdio_oe,
    // RMII towards the MAC
    input  wire logic             txen,
    input  wire logic [1:0]       txd,
    output phy_pkg::rx_bus_t      rmii_rx,
    // Line side
    input  wire logic             energy_in,
    input  wire phy_pkg::rx_bus_t line_rx,
    input  wire logic             line_lpi_code,
    input  wire logic             an_speed_100,
    input  wire logic             an_full_duplex,
    input  wire logic             an_done,
    input  wire logic             link_up,
    input  wire logic             autoneg_strap,
    // Status and control outputs
    output logic                  energy_present_out,
    output logic                  deep_sleep,
    output logic                  tx_lpi,
    output logic                  refresh_burst,
    output logic                  speed_100,
    output logic                  full_duplex,
    output logic                  an_restart,
    output logic                  power_down
);
    logic [2:0]           pin_a_q, pin_b_q, pin_c_q, pin_lvl_q;
    logic                 mdc_rise, mdc_fall, mdio_bit, energy;
    phy_pkg::mdio_st_t    md_st_q;
    phy_pkg::power_st_t   pw_st_q;
    logic [5:0]           ones_q;
    logic [4:0]           cnt_q, reg_q;
    logic [17:0]          sh_q;
    logic [15:0]          wr_data_q, hdr;
    logic                 wr_stb_q, rd_stb_q;
    phy_pkg::basic_ctl_t  bc_q;
    logic [15:0]          ind_ctl_q, ind_addr_q, eee_adv_q, func_q;
    logic [15:0]          sleep_vol_q, sleep_ret_q, afe2_q, afe2_ret_q;
    logic                 eee_on_q, ind_hit, vol_rst, loop_eff, det_done;
    logic [10:0]          det_q, det_lim;
    logic [31:0]          ref_q;
    phy_pkg::rx_bus_t     rx_q;
    logic                 mdio_out_q, mdio_oe_q, ep_q, tx_lpi_q, ref_on_q;
    logic                 speed_q, duplex_q;

    function automatic logic wr_to(input logic [4:0] a);
        return wr_stb_q && (reg_q == a);
    endfunction

    // Read decode; unmapped indices read as zero
    function automatic logic [15:0] rd_word(input logic [4:0] a);
        logic [15:0] st;
        st = phy_pkg::STATUS_FIXED;
        st[phy_pkg::STAT_AN_DONE] = an_done;
        st[phy_pkg::STAT_LINK] = link_up;
        case (a)
            phy_pkg::REG_BASIC:      return bc_q;
            phy_pkg::REG_STATUS:     return st;
            phy_pkg::REG_IND_CTL:    return ind_ctl_q;
            phy_pkg::REG_IND_DATA:
                return (ind_ctl_q[15:14] == phy_pkg::FN_ADDR) ? ind_addr_q
                     : (ind_hit ? eee_adv_q : phy_pkg::ZERO_RST);
            phy_pkg::REG_ANALOG_TWO:
                return sleep_vol_q[phy_pkg::SLP_RETAIN]
                     ? ((afe2_q & ~phy_pkg::ANALOG_KEEP) | afe2_ret_q) : afe2_q;
            phy_pkg::REG_SLEEP:
                return sleep_vol_q[phy_pkg::SLP_RETAIN] ? sleep_ret_q : sleep_vol_q;
            phy_pkg::REG_FUNC_CTL:   return func_q;
            default:                 return phy_pkg::ZERO_RST;
        endcase
    endfunction

    // Pin synchronisers; a level counts once the second and third stages agree
    // Mdc and mdio reset to their idle-high level so no false edge follows reset
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_a_q   <= 3'h3;
            pin_b_q   <= 3'h3;
            pin_c_q   <= 3'h3;
            pin_lvl_q <= 3'h3;
        end
        else
        begin
            pin_a_q   <= {energy_in, mdio_in, mdc};
            pin_b_q   <= pin_a_q;
            pin_c_q   <= pin_b_q;
            pin_lvl_q <= (pin_b_q & pin_c_q) | (pin_lvl_q & (pin_b_q ^ pin_c_q));
        end
    end
    assign mdc_rise = pin_b_q[0] & pin_c_q[0] & ~pin_lvl_q[0];
    assign mdc_fall = ~pin_b_q[0] & ~pin_c_q[0] & pin_lvl_q[0];
    assign mdio_bit = pin_lvl_q[1];
    assign energy   = pin_lvl_q[2];
    assign hdr      = {sh_q[14:0], mdio_bit};
    assign ind_hit  = ind_ctl_q[4:0] == phy_pkg::EEE_DEV && ind_addr_q == phy_pkg::EEE_ADV_REG;

    // Serial management frame engine; idle while asleep
    always_ff @(posedge sys_clk)
    begin
        wr_stb_q <= 1'b0;
        rd_stb_q <= 1'b0;
        if (sys_rst || pw_st_q == phy_pkg::PW_SLEEP)
        begin
            md_st_q    <= phy_pkg::MD_IDLE;
            ones_q     <= 6'h00;
            cnt_q      <= 5'h00;
            sh_q       <= 18'h0_0000;
            reg_q      <= 5'h00;
            wr_data_q  <= 16'h0000;
            mdio_out_q <= 1'b0;
            mdio_oe_q  <= 1'b0;
        end
        else
        begin
            unique case (md_st_q)
                phy_pkg::MD_IDLE:
                    if (mdc_rise)
                    begin
                        if (mdio_bit)
                            ones_q <= (ones_q == phy_pkg::PREAMBLE_LEN) ? ones_q : ones_q + 6'h01;
                        else
                        begin
                            ones_q <= 6'h00;
                            cnt_q  <= 5'h00;
                            if (ones_q == phy_pkg::PREAMBLE_LEN)
                                md_st_q <= phy_pkg::MD_HDR;
                        end
                    end
                phy_pkg::MD_HDR:
                    if (mdc_rise)
                    begin
                        sh_q  <= {sh_q[16:0], mdio_bit};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'd12)
                        begin
                            cnt_q   <= 5'h00;
                            reg_q   <= hdr[4:0];
                            md_st_q <= phy_pkg::MD_IDLE;
                            if (hdr[12] && hdr[9:5] == PHY_ADDR && hdr[11:10] == 2'h1)
                                md_st_q <= phy_pkg::MD_WR;
                            if (hdr[12] && hdr[9:5] == PHY_ADDR && hdr[11:10] == 2'h2)
                            begin
                                md_st_q  <= phy_pkg::MD_RD;
                                sh_q     <= {2'h0, rd_word(hdr[4:0])};
                                rd_stb_q <= hdr[4:0] == phy_pkg::REG_IND_DATA;
                            end
                        end
                    end
                phy_pkg::MD_WR:
                    if (mdc_rise)
                    begin
                        sh_q  <= {sh_q[16:0], mdio_bit};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'd17)
                        begin
                            wr_stb_q  <= 1'b1;
                            wr_data_q <= hdr;
                            md_st_q   <= phy_pkg::MD_IDLE;
                        end
                    end
                phy_pkg::MD_RD:
                    if (mdc_fall)
                    begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'd1)
                        begin
                            mdio_oe_q  <= 1'b1;
                            mdio_out_q <= 1'b0;
                        end
                        else if (cnt_q == 5'd18)
                        begin
                            mdio_oe_q <= 1'b0;
                            md_st_q   <= phy_pkg::MD_IDLE;
                        end
                        else if (cnt_q != 5'd0)
                        begin
                            mdio_out_q <= sh_q[15];
                            sh_q       <= {sh_q[16:0], 1'b0};
                        end
                    end
            endcase
        end
    end

    // Volatile registers are lost in sleep and defaulted by software reset
    assign vol_rst = sys_rst || bc_q.soft_reset || pw_st_q == phy_pkg::PW_SLEEP;
    always_ff @(posedge sys_clk)
    begin
        if (vol_rst)
        begin
            bc_q           <= phy_pkg::BASIC_RST;
            bc_q.an_enable <= autoneg_strap;
        end
        else
        begin
            bc_q.soft_reset <= 1'b0;
            bc_q.restart_an <= 1'b0;
            if (wr_to(phy_pkg::REG_BASIC))
            begin
                if (bc_q.power_down && wr_data_q[15])
                    bc_q.power_down <= 1'b0;
                else
                    bc_q <= {wr_data_q[15:7], 7'h00};
            end
        end
    end

    // Indirect space and idle-function enable
    always_ff @(posedge sys_clk)
    begin
        if (vol_rst)
        begin
            ind_ctl_q  <= phy_pkg::ZERO_RST;
            ind_addr_q <= phy_pkg::ZERO_RST;
            eee_adv_q  <= phy_pkg::ZERO_RST;
            func_q     <= phy_pkg::ZERO_RST;
            eee_on_q   <= 1'b0;
        end
        else
        begin
            if (wr_to(phy_pkg::REG_IND_CTL))
                ind_ctl_q <= wr_data_q;
            if (wr_to(phy_pkg::REG_FUNC_CTL))
                func_q <= wr_data_q;
            if (wr_to(phy_pkg::REG_IND_DATA))
            begin
                if (ind_ctl_q[15:14] == phy_pkg::FN_ADDR)
                    ind_addr_q <= wr_data_q;
                else
                begin
                    if (ind_hit)
                        eee_adv_q <= wr_data_q;
                    if (ind_ctl_q[15])
                        ind_addr_q <= ind_addr_q + 16'h0001;
                end
            end
            if (rd_stb_q && ind_ctl_q[15:14] == phy_pkg::FN_INC_RW)
                ind_addr_q <= ind_addr_q + 16'h0001;
            if (wr_to(phy_pkg::REG_BASIC) && wr_data_q[9])
                eee_on_q <= eee_adv_q[phy_pkg::EEE_ADV_BIT];
        end
    end

    // Sleep control with retained copies; only hardware reset clears them
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sleep_vol_q <= phy_pkg::ZERO_RST;
            sleep_ret_q <= phy_pkg::ZERO_RST;
            afe2_q      <= phy_pkg::ZERO_RST;
            afe2_ret_q  <= phy_pkg::ZERO_RST;
        end
        else if (pw_st_q == phy_pkg::PW_SLEEP)
        begin
            sleep_vol_q <= sleep_ret_q;
            afe2_q      <= afe2_ret_q;
        end
        else
        begin
            if (wr_to(phy_pkg::REG_SLEEP))
            begin
                sleep_vol_q <= wr_data_q;
                if (wr_data_q[phy_pkg::SLP_RETAIN])
                    sleep_ret_q <= wr_data_q;
            end
            if (wr_to(phy_pkg::REG_ANALOG_TWO))
            begin
                afe2_q <= wr_data_q;
                if (sleep_vol_q[phy_pkg::SLP_RETAIN])
                    afe2_ret_q <= wr_data_q & phy_pkg::ANALOG_KEEP;
            end
        end
    end

    // Energy loss timer and power state
    assign det_lim  = sleep_vol_q[phy_pkg::SLP_EXT] ? phy_pkg::DET_LONG_CYC
                                                    : phy_pkg::DET_SHORT_CYC;
    assign det_done = det_q >= det_lim;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || energy || !sleep_vol_q[phy_pkg::SLP_EN])
            det_q <= 11'h000;
        else if (!det_done)
            det_q <= det_q + 11'h001;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            pw_st_q <= phy_pkg::PW_RUN;
        else
        begin
            unique case (pw_st_q)
                phy_pkg::PW_RUN:
                    if (sleep_vol_q[phy_pkg::SLP_EN] && (sleep_vol_q[phy_pkg::SLP_METHOD]
                        ? sleep_vol_q[phy_pkg::SLP_MANUAL] : det_done))
                        pw_st_q <= phy_pkg::PW_SLEEP;
                phy_pkg::PW_SLEEP:
                    if (!sleep_vol_q[phy_pkg::SLP_METHOD] && energy)
                        pw_st_q <= phy_pkg::PW_RUN;
            endcase
        end
    end

    // Energy output is forced true until the feature is enabled
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ep_q <= 1'b1;
        else if (!sleep_vol_q[phy_pkg::SLP_EN])
            ep_q <= 1'b1;
        else
            ep_q <= !det_done ^ sleep_vol_q[phy_pkg::SLP_POL];
    end

    // Transmit idle and refresh bursts
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            tx_lpi_q <= 1'b0;
        else
            tx_lpi_q <= eee_on_q && !txen && txd == phy_pkg::LPI_CODE
                        && pw_st_q == phy_pkg::PW_RUN;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !tx_lpi_q)
        begin
            ref_q    <= 32'h0000_0000;
            ref_on_q <= 1'b0;
        end
        else
        begin
            ref_q    <= (ref_q == 32'(REFRESH_PERIOD - 1)) ? 32'h0000_0000 : ref_q + 32'h0000_0001;
            ref_on_q <= ref_q < 32'(REFRESH_BURST);
        end
    end

    // RMII receive, loopback and isolation; receive idle is separate from transmit
    assign loop_eff = bc_q.loopback && func_q[phy_pkg::FUNC_LOOP];
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || bc_q.isolate || bc_q.power_down || pw_st_q == phy_pkg::PW_SLEEP)
            rx_q <= '0;
        else if (loop_eff)
            rx_q <= {txen, txd};
        else if (eee_on_q && line_lpi_code)
            rx_q <= {1'b0, phy_pkg::LPI_CODE};
        else
            rx_q <= line_rx;
    end

    // Negotiated result wins over the manual bits
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            speed_q  <= 1'b1;
            duplex_q <= 1'b1;
        end
        else
        begin
            speed_q  <= bc_q.an_enable ? an_speed_100 : bc_q.speed_100;
            duplex_q <= bc_q.an_enable ? an_full_duplex : bc_q.full_duplex;
        end
    end

    assign mdio_out           = mdio_out_q;
    assign mdio_oe            = mdio_oe_q;
    assign rmii_rx            = rx_q;
    assign energy_present_out = ep_q;
    assign deep_sleep         = pw_st_q == phy_pkg::PW_SLEEP;
    assign tx_lpi             = tx_lpi_q;
    assign refresh_burst      = ref_on_q;
    assign speed_100          = speed_q;
    assign full_duplex        = duplex_q;
    assign an_restart         = bc_q.restart_an;
    assign power_down         = bc_q.power_down;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    energy_forced_a: assert property (!sleep_vol_q[3] |=> energy_present_out)
        else $error("energy output not forced high");
    retain_gate_a: assert property (wr_to(phy_pkg::REG_SLEEP) && !wr_data_q[4] && !deep_sleep
        |=> $stable(sleep_ret_q))
        else $error("retained copy written without gate bit");
    auto_sleep_a: assert property (!deep_sleep && sleep_vol_q[3] && !sleep_vol_q[6] && det_done
        |=> deep_sleep)
        else $error("no automatic sleep entry");
    auto_wake_a: assert property (deep_sleep && !sleep_vol_q[6] && energy && !sleep_vol_q[0]
        |=> !deep_sleep ##1 energy_present_out)
        else $error("no automatic wake");
    soft_keep_a: assert property (bc_q.soft_reset && !deep_sleep |=> $stable(sleep_ret_q))
        else $error("retained copy lost on software reset");
    lpi_exit_a: assert property (tx_lpi && (txen || txd != 2'h1) |=> !tx_lpi)
        else $error("transmit idle not left");
    refresh_start_a: assert property ($rose(tx_lpi) |=> refresh_burst)
        else $error("refresh burst missing");
    restart_pulse_a: assert property (an_restart |=> !an_restart)
        else $error("restart bit did not clear");
    rx_lpi_a: assert property (eee_on_q && line_lpi_code && !loop_eff && !bc_q.isolate
        && !bc_q.power_down && !deep_sleep |=> rmii_rx == 3'b001)
        else $error("receive idle code wrong");
    self_clear_a: assert property (bc_q.soft_reset |=> !bc_q.soft_reset)
        else $error("reset bit did not clear");
    isolate_a: assert property (bc_q.isolate |=> rmii_rx == 3'b000)
        else $error("receive not isolated");
    an_override_a: assert property (bc_q.an_enable |=> speed_100 == $past(an_speed_100))
        else $error("speed not from negotiation");
    pd_two_a: assert property (wr_to(phy_pkg::REG_BASIC) && wr_data_q[15] && bc_q.power_down
        |=> !bc_q.power_down && !bc_q.soft_reset)
        else $error("first reset write did more than leave power-down");

    sleep_seen_c: cover property (!deep_sleep ##1 deep_sleep ##[1:50] !deep_sleep);
    lpi_seen_c: cover property ($rose(tx_lpi) ##[1:300] $fell(tx_lpi));
    read_seen_c: cover property ($rose(mdio_oe) ##[1:400] $fell(mdio_oe));
endmodule

// ===== verif/mgmt_host.sv
/*
  Management host model: serial frames on mdc/mdio.
  Assumes the wire has a pull-up and PHY address 1.
*/
`timescale 1ns/1ps
module mgmt_host (
    // Pins
    output logic            mdc,
    output logic            mdio_in,
    input  wire logic       mdio_out,
    input  wire logic       mdio_oe
);
    logic hoe = 1'b0;
    logic hb  = 1'b1;
    initial mdc = 1'b1;
    // Pull-up wins when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (hoe ? hb : 1'b1);
    // Data moves with the fall, so it is held across the sampling rise
    task automatic bits(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            hoe = 1'b1;
            mdc = 1'b0;
            hb  = v[i];
            #160 mdc = 1'b1;
            #160;
        end
    endtask
    task automatic frame(input logic rd, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [17:0] s;
        s = 18'h0_0000;
        bits(64'({32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra}), 46);
        if (rd)
        begin
            hoe = 1'b0;
            for (int i = 0; i < 18; i++)
            begin
                mdc = 1'b0;
                #160 mdc = 1'b1;
                #159 s = {s[16:0], mdio_in};
                #1;
            end
            q = s[15:0];
            mdc = 1'b0;
            #160 mdc = 1'b1;
            #160;
        end
        else
        begin
            bits({46'h0, 2'b10, wd}, 18);
            q = wd;
        end
        hoe = 1'b0;
    endtask
endmodule

// ===== verif/tb.sv
/*
  Self-checking bench for the sleep, idle and management block.
  Assumes mgmt_host drives the management pins.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    logic        sys_clk = 0, sys_rst = 1, txen = 0, en = 1, lpi = 0, strap = 1;
    logic [1:0]  txd = 0;
    logic [2:0]  lrx = 0, rx;
    logic [3:0]  an;
    logic [15:0] d;
    logic [8:0]  n;
    logic [7:0]  ar_n = 8'h00;
    logic        mdc, mdi, mdo, moe, ep, ds, tl, rb, sp, fd, ar, pd;
    int          fail_count = 0, checks = 0;
    always #20 sys_clk = ~sys_clk;
    always @(negedge sys_clk) ar_n <= ar_n + {7'h00, ar};
    mgmt_host i_mgmt_host(.mdc(mdc), .mdio_in(mdi), .mdio_out(mdo), .mdio_oe(moe));
    phy_sleep_lpi_control #(.REFRESH_PERIOD(200), .REFRESH_BURST(20))
    i_phy_sleep_lpi_control(.sys_clk(sys_clk), .sys_rst(sys_rst), .mdc(mdc),
        .mdio_in(mdi), .mdio_out(mdo), .mdio_oe(moe), .txen(txen), .txd(txd),
        .rmii_rx(rx), .energy_in(en), .line_rx(lrx), .line_lpi_code(lpi),
        .an_speed_100(an[3]), .an_full_duplex(an[2]), .an_done(an[1]),
        .link_up(an[0]), .autoneg_strap(strap), .energy_present_out(ep),
        .deep_sleep(ds), .tx_lpi(tl), .refresh_burst(rb), .speed_100(sp),
        .full_duplex(fd), .an_restart(ar), .power_down(pd));
    task automatic rd(input logic [4:0] a);
        i_mgmt_host.frame(1'b1, a, 16'h0000, d);
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        i_mgmt_host.frame(1'b0, a, v, d);
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #2_000_000 fail_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'h4db8));
        an = 4'($urandom);
        repeat (4) @(negedge sys_clk);
        sys_rst = 0;
        `CHK(ep, 1'b1)
        rd(phy_pkg::REG_BASIC);
        `CHK(d, 16'h3100)
        rd(phy_pkg::REG_STATUS);
        `CHK(d, phy_pkg::STATUS_FIXED | {10'h0, an[1], 2'b00, an[0], 2'b00})
        `CHK({sp, fd}, an[3:2])
        rd(5'h1F);
        `CHK(d, 16'h0000)
        $display("test registers done");
        // Idle advertisement through the indirect window, then restart
        wr(phy_pkg::REG_IND_CTL, 16'h0007);
        wr(phy_pkg::REG_IND_DATA, 16'h003C);
        wr(phy_pkg::REG_IND_CTL, 16'h4007);
        wr(phy_pkg::REG_IND_DATA, 16'h0002);
        wr(phy_pkg::REG_BASIC, 16'h3300);
        `CHK(ar_n, 8'h01)
        @(negedge sys_clk);
        txd = 2'b01;
        @(negedge sys_clk);
        `CHK(tl, 1'b1)
        @(negedge sys_clk);
        `CHK(rb, 1'b1)
        n = 9'h000;
        repeat (200)
        begin
            n = n + {8'h00, rb};
            @(negedge sys_clk);
        end
        `CHK(n, 9'h014)
        txd = 2'b00;
        @(negedge sys_clk);
        `CHK(tl, 1'b0)
        for (int i = 0; i < 8; i++)
        begin
            lrx = 3'($urandom);
            lpi = 1'($urandom);
            @(negedge sys_clk);
            `CHK(rx, lpi ? 3'b001 : lrx)
        end
        lpi = 0;
        wr(phy_pkg::REG_FUNC_CTL, 16'h0002);
        wr(phy_pkg::REG_BASIC, 16'h4000);
        txen = 1;
        txd = 2'($urandom);
        @(negedge sys_clk);
        `CHK(rx, {1'b1, txd})
        txen = 0;
        txd = 2'b00;
        wr(phy_pkg::REG_BASIC, 16'h0400);
        lrx = 3'h7;
        @(negedge sys_clk);
        `CHK(rx, 3'h0)
        $display("test idle done");
        wr(phy_pkg::REG_BASIC, 16'h8000);
        rd(phy_pkg::REG_BASIC);
        `CHK(d, 16'h3100)
        txd = 2'b01;
        repeat (2) @(negedge sys_clk);
        `CHK(tl, 1'b0)
        txd = 2'b00;
        wr(phy_pkg::REG_BASIC, 16'h0800);
        `CHK(pd, 1'b1)
        wr(phy_pkg::REG_BASIC, 16'h8000);
        rd(phy_pkg::REG_BASIC);
        `CHK(d, 16'h0000)
        wr(phy_pkg::REG_BASIC, 16'h8000);
        rd(phy_pkg::REG_BASIC);
        `CHK(d, 16'h3100)
        $display("test soft reset done");
        wr(phy_pkg::REG_SLEEP, 16'h001A);
        rd(phy_pkg::REG_SLEEP);
        `CHK(d, 16'h001A)
        en = 0;
        repeat (1100) @(negedge sys_clk);
        `CHK({ds, ep}, 2'b10)
        en = 1;
        repeat (8) @(negedge sys_clk);
        `CHK({ds, ep}, 2'b01)
        rd(phy_pkg::REG_SLEEP);
        `CHK(d, 16'h001A)
        sys_rst = 1;
        repeat (4) @(negedge sys_clk);
        sys_rst = 0;
        rd(phy_pkg::REG_SLEEP);
        `CHK(d, 16'h0000)
        wr(phy_pkg::REG_SLEEP, 16'h0008);
        rd(phy_pkg::REG_SLEEP);
        `CHK(d, 16'h0008)
        `CHK(ep, 1'b1)
        $display("test sleep done");
        print_verdict();
    end
endmodule
